// [lcd_bias_supply_control.sv]
// What this block does
// - source 10 asserts only pin switch
// - source 11 deasserts all three switches
// - follower on only unbypassed with pin switch
// - doubler select picks two-thirds or direct with pin switch
// - regulator enable connects regulated source
// - doubler select picks regulator target
// - signed trim, 1.5 percent steps, clamped
// - pump unselected enables resistor network
// - reset clears display enable, drivers float
// - reset restores duty, bias, other fields
// - frame event sets sticky irq flag
// - writing one clears flag, zero ignored
// - irq out when flag and enable
// - reset source ties top level to main
// - drivers off 16 ticks after pump enable
//
// Purpose: bias supply switch, follower, pump and regulator control
// Assumes: bus strobes synchronous to ref_clk, one cycle each
// Notes:   timebase tick is a one-cycle pulse from the frame timer
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "bias_supply_map.svh"

module lcd_bias_supply_control
  import bias_supply_pkg::*;
#(
  parameter int BLANK_TICKS = `PUMP_BLANK_TICKS
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // register port
  input  wire reg_req_t     bus_req,
  output logic [7:0]        bus_rdata,
  // events
  input  wire logic         frame_event,
  input  wire logic         timebase_tick,
  // analog and driver controls
  output analog_ctrl_t      analog_ctrl,
  output logic              drivers_enable,
  output logic [2:0]        duty_select,
  output logic              bias_third,
  output logic [2:0]        frame_clock_select,
  output logic [2:0]        blink_rate_select,
  output logic              irq
);

  // control registers
  logic [1:0] bias_source_select;
  logic       doubler_tripler_select;
  logic       follower_bypass;
  logic       pump_select;
  logic       regulator_enable;
  logic [3:0] trim_code;
  logic       display_enable;
  logic       frame_irq_enable;
  logic       frame_irq_flag;
  logic [4:0] blank_count;
  pump_state_t pump_state;
  analog_ctrl_t next_analog;

  // trim clamp in counts; a four-bit code stays inside it, a wider one would not
  localparam logic signed [4:0] TRIM_LIMIT = 5'(`TRIM_MAX_COUNTS);

  logic wr_supply;
  logic wr_trim;
  logic wr_ctl_one;
  logic wr_ctl_two;
  logic wr_status;

  // address decode for writes
  function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  assign wr_supply  = hit(bus_req, `OFS_SUPPLY_CONFIG);
  assign wr_trim    = hit(bus_req, `OFS_TRIM);
  assign wr_ctl_one = hit(bus_req, `OFS_CONTROL_ONE);
  assign wr_ctl_two = hit(bus_req, `OFS_CONTROL_TWO);
  assign wr_status  = hit(bus_req, `OFS_STATUS);

  // supply configuration register; reset picks top-from-main
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bias_source_select     <= `RST_SOURCE;
      doubler_tripler_select <= 1'b0;
      follower_bypass        <= 1'b0;
      pump_select            <= 1'b0;
    end else if (wr_supply) begin
      bias_source_select     <= bus_req.wdata[`FLD_SOURCE_HI:`FLD_SOURCE_LO];
      doubler_tripler_select <= bus_req.wdata[`FLD_DOUBLER];
      follower_bypass        <= bus_req.wdata[`FLD_BYPASS];
      pump_select            <= bus_req.wdata[`FLD_PUMP_SEL];
    end
  end

  // regulator register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      regulator_enable <= 1'b0;
      trim_code        <= 4'h0;
    end else if (wr_trim) begin
      regulator_enable <= bus_req.wdata[`FLD_REG_EN];
      trim_code        <= bus_req.wdata[`FLD_TRIM_HI:`FLD_TRIM_LO];
    end
  end

  // display control registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      display_enable     <= 1'b0;
      duty_select        <= `RST_DUTY;
      bias_third         <= 1'b1;
      frame_clock_select <= `RST_FRAME;
      blink_rate_select  <= `RST_BLINK;
      frame_irq_enable   <= 1'b0;
    end else begin
      if (wr_ctl_one) begin
        display_enable     <= bus_req.wdata[`FLD_DISP_EN];
        duty_select        <= bus_req.wdata[`FLD_DUTY_HI:`FLD_DUTY_LO];
        bias_third         <= bus_req.wdata[`FLD_BIAS_THIRD];
        frame_clock_select <= bus_req.wdata[`FLD_FRAME_HI:`FLD_FRAME_LO];
      end
      if (wr_ctl_two) begin
        frame_irq_enable  <= bus_req.wdata[`FLD_IRQ_EN];
        blink_rate_select <= bus_req.wdata[`FLD_BLINK_HI:`FLD_BLINK_LO];
      end
    end
  end

  // sticky flag: a new event beats a same-cycle clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      frame_irq_flag <= 1'b0;
    end else if (frame_event) begin
      frame_irq_flag <= 1'b1;
    end else if (wr_status && bus_req.wdata[`FLD_IRQ_FLAG]) begin
      frame_irq_flag <= 1'b0;
    end
  end

  // irq registered from flag and enable, one cycle behind them
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= frame_irq_flag && frame_irq_enable;
    end
  end

  // pump start blanking: restarts whenever the pump turns on
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pump_state  <= pump_idle;
      blank_count <= 5'h0;
    end else begin
      case (pump_state)
        pump_idle: begin
          if (next_analog.pump_enable) begin
            pump_state  <= pump_blank;
            blank_count <= 5'h0;
          end
        end
        pump_blank: begin
          if (!next_analog.pump_enable) begin
            pump_state <= pump_idle;
          end else if (timebase_tick) begin
            if (blank_count == 5'(BLANK_TICKS - 1)) begin
              pump_state <= pump_running;
            end
            blank_count <= blank_count + 5'h1;
          end
        end
        default: begin
          if (!next_analog.pump_enable) begin
            pump_state <= pump_idle;
          end
        end
      endcase
    end
  end

  // driver enable gated by display enable and pump blanking
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      drivers_enable <= 1'b0;
    end else begin
      drivers_enable <= display_enable && (pump_state != pump_blank)
                        && !(next_analog.pump_enable && pump_state == pump_idle);
    end
  end

  // decode from registered bits only, so writes cannot glitch analog side
  always_comb begin
    logic signed [4:0] t;
    t = 5'(signed'(trim_code));
    next_analog = '0;
    case (bias_source_t'(bias_source_select))
      src_mid_main: next_analog.switch_mid_from_main = 1'b1;
      src_top_main: next_analog.switch_top_from_main = 1'b1;
      src_low_pin:  next_analog.switch_low_from_pin  = 1'b1;
      default:      next_analog.switch_low_from_pin  = 1'b0;
    endcase
    next_analog.follower_enable = !follower_bypass
                                  && next_analog.switch_low_from_pin;
    next_analog.divider_two_thirds = next_analog.switch_low_from_pin
                                     && !doubler_tripler_select;
    next_analog.pump_enable     = pump_select;
    next_analog.resistor_enable = !pump_select;
    next_analog.regulator_to_level_one = regulator_enable;
    next_analog.regulator_high_target  = doubler_tripler_select;
    // clamp to plus or minus the trim limit
    if (t > TRIM_LIMIT) begin
      t = TRIM_LIMIT;
    end else if (t < -TRIM_LIMIT) begin
      t = -TRIM_LIMIT;
    end
    next_analog.regulator_trim = t;
  end

  // analog controls straight from flip-flops
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl <= next_analog;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bus_rdata <= 8'h00;
    end else if (!bus_req.rd) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.addr == `OFS_SUPPLY_CONFIG) begin
      bus_rdata <= {pump_select, doubler_tripler_select, 2'b00, follower_bypass,
                    1'b0, bias_source_select};
    end else if (bus_req.addr == `OFS_TRIM) begin
      bus_rdata <= {regulator_enable, 3'b000, trim_code};
    end else if (bus_req.addr == `OFS_CONTROL_ONE) begin
      bus_rdata <= {display_enable, bias_third, frame_clock_select, duty_select};
    end else if (bus_req.addr == `OFS_CONTROL_TWO) begin
      bus_rdata <= {frame_irq_enable, 4'h0, blink_rate_select};
    end else if (bus_req.addr == `OFS_STATUS) begin
      bus_rdata <= {frame_irq_flag, pump_state == pump_blank, drivers_enable, 5'h00};
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  // assertions; analog outputs lag their registers by one edge, hence $past
  a_pin_switch_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(bias_source_select) == 2'h2 && $past(rst_b) |->
      analog_ctrl.switch_low_from_pin && !analog_ctrl.switch_mid_from_main
      && !analog_ctrl.switch_top_from_main)
    else $error("pin source switches wrong");
  a_external_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(bias_source_select) == 2'h3 && $past(rst_b) |->
      analog_ctrl[13:11] == 3'h0)
    else $error("external source has switch on");
  a_follower_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    analog_ctrl.follower_enable |->
      analog_ctrl.switch_low_from_pin && !$past(follower_bypass))
    else $error("follower on illegally");
  a_divider_select: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(bias_source_select) == 2'h2 && $past(rst_b) |->
      analog_ctrl.divider_two_thirds == !$past(doubler_tripler_select))
    else $error("divider select wrong");
  // first edge after reset still sees the cleared controls
  a_resistor_pump: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> analog_ctrl.resistor_enable != analog_ctrl.pump_enable)
    else $error("pump and resistors both on");
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
    frame_event |=> frame_irq_flag)
    else $error("frame flag not set");
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_status && bus_req.wdata[`FLD_IRQ_FLAG] && !frame_event |=> !frame_irq_flag)
    else $error("flag clear lost");
  a_irq_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
    frame_irq_flag && frame_irq_enable |=> irq)
    else $error("irq missing");
  a_pump_blank: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(next_analog.pump_enable) |=> !drivers_enable [*2])
    else $error("drivers on during pump start");
  a_reset_state: assert property (@(posedge ref_clk)
    !rst_b |=> !drivers_enable && bias_source_select == 2'h1
      && duty_select == 3'h3)
    else $error("reset values wrong");

  c_pin_mode: cover property (@(posedge ref_clk) analog_ctrl.follower_enable);
  c_irq: cover property (@(posedge ref_clk) irq);
  c_pump_run: cover property (@(posedge ref_clk) pump_state == pump_running);
  c_set_clear: cover property (@(posedge ref_clk) frame_event && wr_status);
  c_blank_shown: cover property (@(posedge ref_clk) pump_state == pump_blank && display_enable);

endmodule : lcd_bias_supply_control

// [bias_supply_map.svh]
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: plain register port with byte offsets
// Notes:   included by the design and the bench
`ifndef BIAS_SUPPLY_MAP_SVH
`define BIAS_SUPPLY_MAP_SVH

// register offsets
`define OFS_SUPPLY_CONFIG   8'h00
`define OFS_TRIM            8'h01
`define OFS_CONTROL_ONE     8'h02
`define OFS_CONTROL_TWO     8'h03
`define OFS_STATUS          8'h04

// supply config fields
`define FLD_SOURCE_LO       0
`define FLD_SOURCE_HI       1
`define FLD_BYPASS          3
`define FLD_DOUBLER         6
`define FLD_PUMP_SEL        7
// trim register fields
`define FLD_TRIM_LO         0
`define FLD_TRIM_HI         3
`define FLD_REG_EN          7
// control one fields
`define FLD_DUTY_LO         0
`define FLD_DUTY_HI         2
`define FLD_FRAME_LO        3
`define FLD_FRAME_HI        5
`define FLD_BIAS_THIRD      6
`define FLD_DISP_EN         7
// control two fields
`define FLD_IRQ_EN          7
`define FLD_BLINK_LO        0
`define FLD_BLINK_HI        2
// status fields
`define FLD_IRQ_FLAG        7
`define FLD_BLANKED         6
`define FLD_DRV_ON          5

// reset values
`define RST_SOURCE          2'h1
`define RST_DUTY            3'h3
`define RST_FRAME           3'h0
`define RST_BLINK           3'h0

// trim steps: 1.5 percent each, clamp at 12 percent -> 8 counts
`define TRIM_STEP_PERMILLE  15
`define TRIM_LIMIT_PERMILLE 120
`define TRIM_MAX_COUNTS     (`TRIM_LIMIT_PERMILLE / `TRIM_STEP_PERMILLE)

// pump start blanking in timebase cycles
`define PUMP_BLANK_TICKS    16

`endif

// [bias_supply_pkg.sv]
// Purpose: shared types for the bias supply control block
// Assumes: map header holds every number
// Notes:   types only
package bias_supply_pkg;

  // analog control bundle driven to the supply macro
  typedef struct packed {
    logic       switch_mid_from_main;
    logic       switch_top_from_main;
    logic       switch_low_from_pin;
    logic       follower_enable;
    logic       divider_two_thirds;
    logic       pump_enable;
    logic       resistor_enable;
    logic       regulator_to_level_one;
    logic       regulator_high_target;
    logic [4:0] regulator_trim;
  } analog_ctrl_t;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef enum logic [1:0] {
    src_mid_main,
    src_top_main,
    src_low_pin,
    src_external
  } bias_source_t;

  typedef enum {
    pump_idle,
    pump_blank,
    pump_running
  } pump_state_t;

endpackage : bias_supply_pkg

// [bias_far_side.sv]
// Purpose: far-side model, timebase ticks and the external top node
// Assumes: ticks are one-cycle pulses, four cycles apart
// Notes:   ticks stop while tick_run is low, so blanking can be held off
`timescale 1ns/100ps
module bias_far_side
  import bias_supply_pkg::*;
(
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  // bench control and analog side
  input  wire logic          tick_run,
  input  wire analog_ctrl_t  analog_ctrl,
  // timer outputs
  output logic               timebase_tick,
  output logic [7:0]         tick_count,
  output logic               top_from_outside
);
  logic [1:0] phase;

  // tick generator; a stall restarts the phase so counts start clean
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !tick_run) begin
      phase         <= 2'h0;
      timebase_tick <= 1'b0;
    end else begin
      phase         <= phase + 2'h1;
      timebase_tick <= (phase == 2'h3);
    end
  end

  // ticks handed out since the last stall
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !tick_run) begin
      tick_count <= 8'h00;
    end else if (timebase_tick) begin
      tick_count <= tick_count + 8'h01;
    end
  end

  // outside supply drives the top node when no internal source feeds it
  assign top_from_outside = !(analog_ctrl.switch_mid_from_main
                              | analog_ctrl.switch_top_from_main
                              | analog_ctrl.switch_low_from_pin
                              | analog_ctrl.regulator_to_level_one);
endmodule : bias_far_side

// [lcd_bias_supply_control_tb.sv]
// Purpose: self-checking bench for the bias supply control block
// Assumes: pump blanking shortened to two ticks
// Notes:   settle waits three cycles to cover the two-cycle decode lag
`timescale 1ns/100ps
`include "bias_supply_map.svh"
module lcd_bias_supply_control_tb
  import bias_supply_pkg::*;
;
  localparam int TICKS = 2;
  logic         ref_clk = 1'b0;
  logic         rst_b = 1'b0;
  reg_req_t     req = '0;
  logic         frame_event = 1'b0;
  logic         tick_run = 1'b1;
  logic [7:0]   bus_rdata, tick_count;
  analog_ctrl_t analog;
  logic         timebase_tick, top_ext, drv, irq, bias_third;
  logic [2:0]   duty, frame_sel, blink;
  int           errors = 0;
  int           total_checks = 0;
  logic [7:0]   cfg [6] = '{8'h80, 8'h81, 8'h82, 8'hca, 8'h83, 8'h03};
  logic [13:0]  exp_a [6] = '{14'h2100, 14'h1100, 14'h0f00, 14'h0920, 14'h0100, 14'h0080};

  // clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  lcd_bias_supply_control #(.BLANK_TICKS(TICKS)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(req), .bus_rdata(bus_rdata),
    .frame_event(frame_event), .timebase_tick(timebase_tick), .analog_ctrl(analog),
    .drivers_enable(drv), .duty_select(duty), .bias_third(bias_third),
    .frame_clock_select(frame_sel), .blink_rate_select(blink), .irq(irq));

  bias_far_side i_far (
    .ref_clk(ref_clk), .rst_b(rst_b), .tick_run(tick_run), .analog_ctrl(analog),
    .timebase_tick(timebase_tick), .tick_count(tick_count), .top_from_outside(top_ext));

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge ref_clk);
    req.wr    <= 1'b0;
  endtask : wr

  // data is looked at in the one cycle it stands, then must drop to zero
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge ref_clk);
    req.rd   <= 1'b0;
    #1;
    chk(bus_rdata & m, e);
    settle(1);
    chk(bus_rdata, 8'h00);
  endtask : rd

  // bounded wait on the far side's tick count
  task automatic wait_ticks(input logic [7:0] n);
    for (int i = 0; i < 100 && tick_count !== n; i++) settle(1);
    if (tick_count !== n) begin
      errors++;
      $display("unexpected at %0t: tick wait ran out", $time);
      test_done();
    end
  endtask : wait_ticks

  task automatic reset_and_check;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    settle(1);
    chk(analog, 14'h1080);
    chk({duty, bias_third, drv, frame_sel, blink, irq},
        {`RST_DUTY, 1'b1, 1'b0, `RST_FRAME, `RST_BLINK, 1'b0});
  endtask : reset_and_check

  initial begin
    reset_and_check(); // pin and waveform data live outside this block
    $display("test reset defaults done");
    // supply mode table, permitted rows only
    for (int k = 0; k < 6; k++) begin
      wr(`OFS_SUPPLY_CONFIG, cfg[k]);
      settle(3);
      chk(analog, exp_a[k]);
      chk(top_ext, k >= 4);
    end
    wr(`OFS_SUPPLY_CONFIG, 8'hc3);
    wr(`OFS_TRIM, 8'h87);
    settle(3);
    chk(analog, 14'h0167);
    chk(top_ext, 1'b0);
    wr(`OFS_TRIM, 8'h88);
    settle(3);
    chk(analog, 14'h0178);
    wr(`OFS_TRIM, 8'h00);
    rd(`OFS_SUPPLY_CONFIG, 8'hcb, 8'hc3);
    rd(8'h10, 8'hff, 8'h00);
    $display("test supply modes done");
    // display on with resistor bias, then pump start blanking
    wr(`OFS_SUPPLY_CONFIG, 8'h03);
    wr(`OFS_CONTROL_ONE, 8'hab);
    settle(3);
    chk({drv, frame_sel, duty, bias_third}, {1'b1, 3'h5, 3'h3, 1'b0});
    tick_run <= 1'b0;
    wr(`OFS_SUPPLY_CONFIG, 8'h83);
    settle(3);
    chk(drv, 1'b0);
    rd(`OFS_STATUS, 8'h60, 8'h40);
    tick_run <= 1'b1;
    wait_ticks(8'h01);
    chk(drv, 1'b0);
    wait_ticks(8'h02);
    settle(3);
    chk(drv, 1'b1);
    rd(`OFS_STATUS, 8'h60, 8'h20);
    $display("test pump blanking done");
    // frame flag, masked then enabled, zero write then one write
    wr(`OFS_CONTROL_TWO, 8'h05);
    @(posedge ref_clk);
    frame_event <= 1'b1;
    @(posedge ref_clk);
    frame_event <= 1'b0;
    settle(3);
    chk({irq, blink}, {1'b0, 3'h5});
    rd(`OFS_STATUS, 8'h80, 8'h80);
    wr(`OFS_STATUS, 8'h00);
    rd(`OFS_STATUS, 8'h80, 8'h80);
    wr(`OFS_CONTROL_TWO, 8'h85);
    settle(3);
    chk(irq, 1'b1);
    wr(`OFS_STATUS, 8'h80);
    settle(3);
    chk(irq, 1'b0);
    rd(`OFS_STATUS, 8'h80, 8'h00);
    $display("test frame flag done");
    // reset in mid-run with display, pump and irq enable on, regulator off
    wr(`OFS_CONTROL_TWO, 8'h85);
    reset_and_check();
    $display("test second reset done");
    test_done();
  end
endmodule : lcd_bias_supply_control_tb
